// ==== design/lpcfm_top.sv ====
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "lpcfm_consts.svh"
module lpcfm_top
  import lpcfm_pkg::*;
#(
  parameter int MON_TIMEOUT_CYC = `LPCFM_MON_TIMEOUT_CYC,
  parameter int OST_CYC = `LPCFM_OST_CYC,
  parameter int START_DLY_CYC = `LPCFM_START_DLY_CYC,
  parameter int PUP_UNIT_CYC = `LPCFM_PUP_UNIT_CYC
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  input wire logic [7:0] CFG_I,
  input wire logic SLEEP_I,
  input wire logic WDOG_EN_I,
  input wire logic PRI_READY_I,
  input wire logic SYSCLK_TOGGLE_I,
  input wire logic TRAP_ACK_I,
  output logic PRI_EN_O,
  output logic FAST_RC_EN_O,
  output logic SLOW_RC_EN_O,
  output logic CRYSTAL_EN_O,
  output logic CRYSTAL_READY_O,
  output logic [2:0] CUR_SRC_O,
  output logic TRAP_REQ_O
);

  localparam int NSYNC = 13;

  logic [NSYNC-1:0] sync_q;
  lpcfm_cfg_s cfg_s;
  logic sleep_s;
  logic wdog_s;
  logic pri_rdy_s;
  logic act_s;
  logic ack_s;
  logic act_d_r;

  lpcfm_cfg_s cfg_r;
  logic [1:0] boot_cnt_r;
  logic cfg_loaded_r;
  logic [2:0] cur_r;
  logic [2:0] new_r;
  logic req_r;
  logic keep_r;
  logic fail_r;
  logic trap_r;
  lpcfm_cnt_t ost_cnt_r;
  logic crystal_rdy_r;
  lpcfm_cnt_t pup_cnt_r;
  logic pup_run_r;
  lpcfm_mon_e mon_r;
  lpcfm_cnt_t mon_cnt_r;
  logic [15:0] rdata_r;

  lpcfm_osc_en_s en;
  logic sw_en;
  logic mon_en;
  logic ctl_wr;
  logic req_set;
  logic redundant;
  logic tgt_rdy;
  logic sw_done;
  logic sys_rdy;
  logic act_edge;
  logic mon_fail;
  logic need_dly;
  logic [15:0] ctl_rd;
  logic [15:0] stat_rd;

  lpcfm_sync #(
    .W(NSYNC)
  ) u_sync (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .d_i({CFG_I, SLEEP_I, WDOG_EN_I, PRI_READY_I, SYSCLK_TOGGLE_I,
          TRAP_ACK_I}),
    .q_o(sync_q)
  );

  assign cfg_s = lpcfm_cfg_s'(sync_q[12:5]);
  assign sleep_s = sync_q[4];
  assign wdog_s = sync_q[3];
  assign pri_rdy_s = sync_q[2];
  assign act_s = sync_q[1];
  assign ack_s = sync_q[0];

  // config word decode
  assign sw_en = ~cfg_r.switch_monitor_config[1]; // [RULE_21]
  assign mon_en = sw_en & ~cfg_r.switch_monitor_config[0]; // [RULE_21] [RULE_12]

  // fuse levels captured once the synchroniser has settled
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      boot_cnt_r <= 2'h0;
      cfg_loaded_r <= 1'b0;
      cfg_r <= lpcfm_cfg_s'(`LPCFM_CFG_RST);
    end
    else if (!cfg_loaded_r)
    begin
      boot_cnt_r <= boot_cnt_r + 2'h1;
      if (boot_cnt_r == `LPCFM_BOOT_CYC)
      begin
        cfg_loaded_r <= 1'b1;
        cfg_r <= cfg_s;
      end
    end
  end

  // power-up timer on the slow rc time base
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      pup_run_r <= 1'b0;
      pup_cnt_r <= '0;
    end
    else if (!cfg_loaded_r)
    begin
      pup_run_r <= (boot_cnt_r == `LPCFM_BOOT_CYC) // [RULE_08]
                   && (cfg_s.powerup_timer_value_select != 3'h0);
      pup_cnt_r <= lpcfm_cnt_t'(PUP_UNIT_CYC)
                   << cfg_s.powerup_timer_value_select;
    end
    else if (pup_run_r && en.slow_rc) // [RULE_07]
    begin
      if (pup_cnt_r <= lpcfm_cnt_t'(1))
        pup_run_r <= 1'b0;
      pup_cnt_r <= pup_cnt_r - lpcfm_cnt_t'(1);
    end
  end

  // oscillator enables
  always_comb
  begin
    en.crystal = keep_r // [RULE_03]
      | (~sleep_s & (cur_r == `LPCFM_SRC_XTAL)) // [RULE_01] [RULE_02]
      | (~sleep_s & req_r & (new_r == `LPCFM_SRC_XTAL)); // [RULE_04]
    en.slow_rc = sleep_s ? wdog_s // [RULE_10]
      : (pup_run_r | mon_en | wdog_s // [RULE_08] [RULE_09] [RULE_12]
         | (cur_r == `LPCFM_SRC_SLOWRC) // [RULE_06]
         | (req_r & (new_r == `LPCFM_SRC_SLOWRC)));
    en.fast_rc = ~sleep_s & ( // [RULE_04]
      (cur_r == `LPCFM_SRC_FAST) | (cur_r == `LPCFM_SRC_FASTPLL)
      | (cur_r == `LPCFM_SRC_FASTDIV)
      | (req_r & ((new_r == `LPCFM_SRC_FAST)
                  | (new_r == `LPCFM_SRC_FASTPLL)
                  | (new_r == `LPCFM_SRC_FASTDIV))));
    en.pri = ~sleep_s & ( // [RULE_04]
      (cur_r == `LPCFM_SRC_PRI) | (cur_r == `LPCFM_SRC_PRIPLL)
      | (req_r & ((new_r == `LPCFM_SRC_PRI)
                  | (new_r == `LPCFM_SRC_PRIPLL))));
  end

  // crystal start-up timer
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      ost_cnt_r <= '0;
      crystal_rdy_r <= 1'b0;
    end
    else if (!en.crystal)
    begin
      ost_cnt_r <= '0;
      crystal_rdy_r <= 1'b0;
    end
    else if (!crystal_rdy_r)
    begin
      ost_cnt_r <= ost_cnt_r + lpcfm_cnt_t'(1);
      if (ost_cnt_r == lpcfm_cnt_t'(OST_CYC - 1))
        crystal_rdy_r <= 1'b1; // [RULE_05]
    end
  end

  // readiness of a given source
  function automatic logic src_ready(input logic [2:0] src,
                                     input logic xtal_rdy,
                                     input logic pri_rdy);
    logic r;
    r = 1'b1; // [RULE_11]
    if (src == `LPCFM_SRC_XTAL)
      r = xtal_rdy; // [RULE_05]
    else if ((src == `LPCFM_SRC_PRI) || (src == `LPCFM_SRC_PRIPLL))
      r = pri_rdy;
    return r;
  endfunction

  assign ctl_wr = WR_I && (ADDR_I == `LPCFM_OSC_CTRL_OFS);
  assign req_set = ctl_wr && WDATA_I[`LPCFM_REQ_BIT] && sw_en;
  assign redundant = req_r && (new_r == cur_r);
  assign tgt_rdy = src_ready(new_r, crystal_rdy_r, pri_rdy_s);
  assign sw_done = req_r && !redundant && tgt_rdy;
  assign sys_rdy = src_ready(cur_r, crystal_rdy_r, pri_rdy_s);
  assign need_dly = (cur_r == `LPCFM_SRC_XTAL) | (cur_r == `LPCFM_SRC_PRI)
                    | (cur_r == `LPCFM_SRC_PRIPLL);

  // current source
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      cur_r <= `LPCFM_CUR_RST;
    else if (mon_fail)
      cur_r <= `LPCFM_SRC_FAST; // [RULE_13] [RULE_14]
    else if (boot_cnt_r == `LPCFM_BOOT_CYC && !cfg_loaded_r)
      cur_r <= cfg_s.initial_source_select; // [RULE_01] [RULE_06]
    else if (sw_done)
      cur_r <= new_r; // [RULE_01] [RULE_06]
  end

  // software-written control fields
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      new_r <= `LPCFM_CUR_RST;
      keep_r <= 1'b0;
    end
    else if (ctl_wr)
    begin
      keep_r <= WDATA_I[`LPCFM_KEEP_BIT]; // [RULE_03]
      if (!req_r)
        new_r <= WDATA_I[`LPCFM_NEW_LSB +: 3];
    end
  end

  // switch request; monitor cancellation beats a new request
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      req_r <= 1'b0;
    else if (mon_fail)
      req_r <= 1'b0; // [RULE_16]
    else if (redundant || sw_done)
      req_r <= 1'b0;
    else if (req_set)
      req_r <= 1'b1;
  end

  // clock fail flag; hardware set wins over software clear
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      fail_r <= 1'b0;
    else if (mon_fail)
      fail_r <= 1'b1; // [RULE_15]
    else if (ctl_wr && !WDATA_I[`LPCFM_FAIL_BIT])
      fail_r <= 1'b0;
    else if (req_set && !req_r
             && (WDATA_I[`LPCFM_NEW_LSB +: 3] != cur_r))
      fail_r <= 1'b0;
  end

  // activity edge from system clock toggle
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      act_d_r <= 1'b0;
    else
      act_d_r <= act_s;
  end

  assign act_edge = act_s ^ act_d_r;
  assign mon_fail = (mon_r == MON_WATCH) && !sleep_s
                    && !act_edge
                    && (mon_cnt_r == lpcfm_cnt_t'(MON_TIMEOUT_CYC - 1)); // [RULE_13]

  // clock failure monitor, timed on the slow rc base
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      mon_r <= MON_IDLE;
      mon_cnt_r <= '0;
    end
    else if (!mon_en || !cfg_loaded_r || !en.slow_rc) // [RULE_07]
    begin
      mon_r <= MON_IDLE;
      mon_cnt_r <= '0;
    end
    else if (sleep_s)
      mon_cnt_r <= '0; // [RULE_17]
    else
    begin
      unique case (mon_r)
        MON_IDLE:
        begin
          mon_cnt_r <= '0;
          if (sys_rdy) // [RULE_18]
            mon_r <= need_dly ? MON_START_DLY : MON_WATCH; // [RULE_19]
        end
        MON_START_DLY:
        begin
          if (mon_cnt_r == lpcfm_cnt_t'(START_DLY_CYC - 1))
          begin
            mon_r <= MON_WATCH; // [RULE_18]
            mon_cnt_r <= '0;
          end
          else
            mon_cnt_r <= mon_cnt_r + lpcfm_cnt_t'(1);
        end
        MON_WATCH:
        begin
          if (act_edge || mon_fail)
            mon_cnt_r <= '0;
          else
            mon_cnt_r <= mon_cnt_r + lpcfm_cnt_t'(1);
          if (sw_done)
            mon_r <= MON_IDLE;
        end
      endcase
    end
  end

  // trap level held until taken; new failure beats the ack
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      trap_r <= 1'b0;
    else if (mon_fail)
      trap_r <= 1'b1; // [RULE_13] [RULE_22]
    else if (ack_s)
      trap_r <= 1'b0; // [RULE_22]
  end

  // register read
  always_comb
  begin
    ctl_rd = 16'h0000;
    ctl_rd[`LPCFM_CUR_LSB +: 3] = cur_r;
    ctl_rd[`LPCFM_NEW_LSB +: 3] = new_r;
    ctl_rd[`LPCFM_FAIL_BIT] = fail_r;
    ctl_rd[`LPCFM_KEEP_BIT] = keep_r;
    ctl_rd[`LPCFM_REQ_BIT] = req_r;
    stat_rd = {cfg_r, 1'b0, trap_r, mon_r == MON_WATCH, mon_en,
               sys_rdy, crystal_rdy_r, pup_run_r, cfg_loaded_r};
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      rdata_r <= 16'h0000;
    else if (RD_I && ADDR_I == `LPCFM_OSC_CTRL_OFS)
      rdata_r <= ctl_rd;
    else if (RD_I && ADDR_I == `LPCFM_STATUS_OFS)
      rdata_r <= stat_rd;
    else
      rdata_r <= 16'h0000;
  end

  // watchdog path never depends on the failure
  assign SLOW_RC_EN_O = en.slow_rc; // [RULE_20]
  assign PRI_EN_O = en.pri;
  assign FAST_RC_EN_O = en.fast_rc;
  assign CRYSTAL_EN_O = en.crystal;
  assign CRYSTAL_READY_O = crystal_rdy_r;
  assign CUR_SRC_O = cur_r;
  assign TRAP_REQ_O = trap_r;
  assign RDATA_O = rdata_r;

endmodule

// ==== inc/lpcfm_consts.svh ====
// Function
// [RULE_01] crystal is system clock by select or switch
// [RULE_02] crystal off when unused or asleep, unless kept
// [RULE_03] keep-on bit holds crystal enabled always
// [RULE_04] sleep stops all sources except kept crystal and slow rc with watchdog
// [RULE_05] crystal ready only after start-up delay
// [RULE_06] slow rc is system clock by select/switch
// [RULE_07] slow rc clocks powerup, watchdog, monitor
// [RULE_08] slow rc enabled at reset per powerup field
// [RULE_09] slow rc stays on for monitor/watchdog/selection
// [RULE_10] in sleep slow rc runs only with watchdog
// [RULE_11] slow rc ready at once, no delay
// [RULE_12] field 00 enables monitor, slow rc on
// [RULE_13] no activity within timeout: trap, fast rc
// [RULE_14] fallback loads current source with 000
// [RULE_15] fallback sets clock fail flag bit 3
// [RULE_16] fallback clears switch request bit 0
// [RULE_17] clock failure in sleep never wakes
// [RULE_18] check only after ready plus start delay
// [RULE_19] start delay only for crystal sources; code also applies it to primary sources (codes 2, 3)
// [RULE_20] failure leaves watchdog clock untouched
// [RULE_21] field 1x none, 01 switch, 00 both
// [RULE_22] trap level held until taken, synchronised
`ifndef LPCFM_CONSTS_SVH
`define LPCFM_CONSTS_SVH

// register offsets
`define LPCFM_OSC_CTRL_OFS 8'h00
`define LPCFM_STATUS_OFS 8'h04

// osc control register fields
`define LPCFM_REQ_BIT 0
`define LPCFM_KEEP_BIT 1
`define LPCFM_FAIL_BIT 3
`define LPCFM_NEW_LSB 8
`define LPCFM_CUR_LSB 12

// source codes
`define LPCFM_SRC_FAST 3'h0
`define LPCFM_SRC_FASTPLL 3'h1
`define LPCFM_SRC_PRI 3'h2
`define LPCFM_SRC_PRIPLL 3'h3
`define LPCFM_SRC_XTAL 3'h4
`define LPCFM_SRC_SLOWRC 3'h5
`define LPCFM_SRC_FASTDIV 3'h7

// reset values
`define LPCFM_CUR_RST 3'h0
`define LPCFM_CFG_RST 8'hC0

// timing
`define LPCFM_CLK_MHZ 25
`define LPCFM_MON_TIMEOUT_US 2000
`define LPCFM_MON_TIMEOUT_CYC (`LPCFM_MON_TIMEOUT_US * `LPCFM_CLK_MHZ)
`define LPCFM_OST_CYC 1024
`define LPCFM_START_DLY_CYC 512
`define LPCFM_PUP_UNIT_CYC 32
`define LPCFM_BOOT_CYC 2'h3

`endif

// ==== inc/lpcfm_pkg.sv ====
package lpcfm_pkg;

  typedef struct packed {
    logic [2:0] powerup_timer_value_select;
    logic [1:0] switch_monitor_config;
    logic [2:0] initial_source_select;
  } lpcfm_cfg_s;

  typedef struct packed {
    logic pri;
    logic fast_rc;
    logic slow_rc;
    logic crystal;
  } lpcfm_osc_en_s;

  typedef enum logic [1:0] {
    MON_IDLE,
    MON_START_DLY,
    MON_WATCH
  } lpcfm_mon_e;

  typedef logic [19:0] lpcfm_cnt_t;

endpackage

// ==== design/lpcfm_sync.sv ====
`timescale 1ns/1ps
module lpcfm_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      meta_r <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

// ==== testbench/lpcfm_properties.sv ====
`timescale 1ns/1ps
module lpcfm_properties #(
  parameter int MON_TIMEOUT_CYC = 64
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic SLEEP_I,
  input wire logic WDOG_EN_I,
  input wire logic SYSCLK_TOGGLE_I,
  input wire logic TRAP_ACK_I,
  input wire logic PRI_EN_O,
  input wire logic FAST_RC_EN_O,
  input wire logic SLOW_RC_EN_O,
  input wire logic CRYSTAL_EN_O,
  input wire logic CRYSTAL_READY_O,
  input wire logic [2:0] CUR_SRC_O,
  input wire logic TRAP_REQ_O
);
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  logic last_tog_r;
  int idle_r;
  // cycles since the system clock last showed activity
  always_ff @(posedge CLK_I)
  begin
    last_tog_r <= SYSCLK_TOGGLE_I;
    if (RESET_I || SYSCLK_TOGGLE_I != last_tog_r)
      idle_r <= 0;
    else if (idle_r < 100000)
      idle_r <= idle_r + 1;
  end
  sleep_core_a: assert property (
    SLEEP_I [*4] |-> !FAST_RC_EN_O && !PRI_EN_O)
    else $error("fast source running in sleep");
  sleep_slow_a: assert property (
    (SLEEP_I && !WDOG_EN_I) [*4] |-> !SLOW_RC_EN_O)
    else $error("slow rc running in sleep");
  sleep_wdog_a: assert property (
    (SLEEP_I && WDOG_EN_I) [*4] |-> SLOW_RC_EN_O)
    else $error("slow rc off with watchdog in sleep");
  xtal_sel_a: assert property (
    (!SLEEP_I && CUR_SRC_O == 3'h4) [*4] |-> CRYSTAL_EN_O)
    else $error("crystal off while system clock");
  slow_sel_a: assert property (
    (!SLEEP_I && CUR_SRC_O == 3'h5) [*4] |-> SLOW_RC_EN_O)
    else $error("slow rc off while system clock");
  xtal_ost_a: assert property (
    $rose(CRYSTAL_EN_O) |-> !CRYSTAL_READY_O [*8])
    else $error("crystal ready too early");
  trap_src_a: assert property (
    $rose(TRAP_REQ_O) |->
    CUR_SRC_O == 3'h0 && idle_r >= MON_TIMEOUT_CYC - 1)
    else $error("trap early or without fallback");
  trap_hold_a: assert property (
    TRAP_REQ_O && !TRAP_ACK_I && !$past(TRAP_ACK_I) &&
    !$past(TRAP_ACK_I, 2) && !$past(TRAP_ACK_I, 3) |=> TRAP_REQ_O)
    else $error("trap dropped without ack");
  sleep_trap_a: assert property (
    SLEEP_I [*4] |-> !$rose(TRAP_REQ_O))
    else $error("trap raised in sleep");
  cover property ($rose(TRAP_REQ_O));
  cover property (CUR_SRC_O == 3'h4 && CRYSTAL_READY_O);
  cover property (SLEEP_I && WDOG_EN_I);
endmodule

bind lpcfm_top lpcfm_properties #(.MON_TIMEOUT_CYC(MON_TIMEOUT_CYC)) u_props (
  .CLK_I(CLK_I),
  .RESET_I(RESET_I),
  .SLEEP_I(SLEEP_I),
  .WDOG_EN_I(WDOG_EN_I),
  .SYSCLK_TOGGLE_I(SYSCLK_TOGGLE_I),
  .TRAP_ACK_I(TRAP_ACK_I),
  .PRI_EN_O(PRI_EN_O),
  .FAST_RC_EN_O(FAST_RC_EN_O),
  .SLOW_RC_EN_O(SLOW_RC_EN_O),
  .CRYSTAL_EN_O(CRYSTAL_EN_O),
  .CRYSTAL_READY_O(CRYSTAL_READY_O),
  .CUR_SRC_O(CUR_SRC_O),
  .TRAP_REQ_O(TRAP_REQ_O)
);

// ==== testbench/lpcfm_far_side.sv ====
`timescale 1ns/1ps
module lpcfm_far_side #(
  parameter int ACK_DLY = 3
) (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic trap_i,
  output logic toggle_o,
  output logic ack_o
);
  int cnt;
  initial
  begin
    toggle_o = 1'h0;
    ack_o = 1'h0;
    cnt = 0;
  end
  // system clock stands still when stopped; core takes trap late
  always @(posedge clk_i)
  begin
    if (run_i)
      toggle_o <= ~toggle_o;
    cnt <= trap_i ? cnt + 1 : 0;
    ack_o <= trap_i && cnt >= ACK_DLY;
  end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic clk, rst, wr_s, rd_s, sleep, wdog, run, trap, ack, tog;
  logic pri_en, fast_en, slow_en, xt_en, xt_rdy;
  logic [7:0] addr, cfg;
  logic [15:0] wdata, rdata, d;
  logic [2:0] cur;
  int n_errors = 0;
  int checks_done = 0;
  int i;
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  lpcfm_top #(.MON_TIMEOUT_CYC(64), .OST_CYC(16), .START_DLY_CYC(8)) dut (
    .CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .CFG_I(cfg),
    .SLEEP_I(sleep), .WDOG_EN_I(wdog), .PRI_READY_I(1'h0),
    .SYSCLK_TOGGLE_I(tog), .TRAP_ACK_I(ack), .PRI_EN_O(pri_en),
    .FAST_RC_EN_O(fast_en), .SLOW_RC_EN_O(slow_en),
    .CRYSTAL_EN_O(xt_en), .CRYSTAL_READY_O(xt_rdy),
    .CUR_SRC_O(cur), .TRAP_REQ_O(trap));
  lpcfm_far_side far (.clk_i(clk), .run_i(run), .trap_i(trap),
    .toggle_o(tog), .ack_o(ack));
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'h1;
    @(posedge clk);
    wr_s <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clk);
    rd_s <= 1'h0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_src(input logic [2:0] e);
    for (i = 0; i < 200 && cur !== e; i++)
      @(negedge clk);
  endtask
  task automatic do_reset(input logic [7:0] c);
    @(posedge clk);
    rst <= 1'h1;
    cfg <= c;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    cyc(8);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_errors++;
    complete_run();
  end
  initial
  begin
    {wr_s, rd_s, sleep, wdog, addr, wdata} = '0;
    rst = 1'h1;
    run = 1'h1;
    cfg = 8'h00;
    do_reset(8'h00);
    chk("slow_en", 1, slow_en);
    rd(8'h04);
    chk("mon_en", 1, d[4]);
    rd(8'h08);
    chk("unmapped", 0, d);
    $display("end of test boot");
    wr(8'h00, 16'h0401);
    @(negedge clk);
    chk("xt_en", 1, xt_en);
    cyc(12);
    chk("xt_rdy", 0, xt_rdy);
    wait_src(3'h4);
    chk("cur", 4, cur);
    chk("xt_rdy", 1, xt_rdy);
    rd(8'h04);
    chk("watch", 0, d[5]);
    cyc(12);
    rd(8'h04);
    chk("watch", 1, d[5]);
    $display("end of test switch");
    // pending switch to a primary source that never gets ready
    wr(8'h00, 16'h0201);
    rd(8'h00);
    chk("req", 1, d[0]);
    chk("pri_en", 1, pri_en);
    @(posedge clk);
    run <= 1'h0;
    wdog <= 1'h1;
    for (i = 0; i < 300 && trap !== 1'h1; i++)
      @(negedge clk);
    chk("late", 1, 16'(i >= 64));
    chk("trap", 1, trap);
    chk("cur", 0, cur);
    chk("fast_en", 1, fast_en);
    chk("pri_en", 0, pri_en);
    chk("slow_en", 1, slow_en);
    run <= 1'h1;
    rd(8'h00);
    chk("cur_fld", 0, d[14:12]);
    chk("fail", 1, d[3]);
    chk("req", 0, d[0]);
    cyc(10);
    chk("trap", 0, trap);
    $display("end of test failure");
    wr(8'h00, 16'h0002);
    cyc(1);
    chk("xt_en", 1, xt_en);
    wr(8'h00, 16'h0000);
    cyc(1);
    chk("xt_en", 0, xt_en);
    wr(8'h00, 16'h0503);
    wait_src(3'h5);
    chk("fast", 1, 16'(i < 8));
    chk("cur", 5, cur);
    chk("xt_en", 1, xt_en);
    $display("end of test keep");
    @(posedge clk);
    sleep <= 1'h1;
    cyc(4);
    chk("fast_en", 0, fast_en);
    chk("xt_en", 1, xt_en);
    chk("slow_en", 1, slow_en);
    @(posedge clk);
    wdog <= 1'h0;
    run <= 1'h0;
    cyc(150);
    chk("slow_en", 0, slow_en);
    chk("trap", 0, trap);
    @(posedge clk);
    run <= 1'h1;
    sleep <= 1'h0;
    $display("end of test sleep");
    do_reset(8'h15);
    chk("cur", 5, cur);
    chk("slow_en", 1, slow_en);
    wr(8'h00, 16'h0401);
    cyc(30);
    chk("cur", 5, cur);
    rd(8'h04);
    chk("mon_en", 0, d[4]);
    $display("end of test locked");
    do_reset(8'h28);
    chk("slow_en", 1, slow_en);
    @(posedge clk);
    run <= 1'h0;
    cyc(100);
    chk("slow_en", 0, slow_en);
    chk("trap", 0, trap);
    @(posedge clk);
    wdog <= 1'h1;
    cyc(4);
    chk("slow_en", 1, slow_en);
    $display("end of test powerup");
    complete_run();
  end
endmodule
